// >>> core/instr_pkg.sv
// How it works
// - AND immediate into direct: read, AND, write
// - AND accumulator into direct, accumulator kept
// - Direct decrement writes back, wraps modulo 256
// - OR direct into accumulator, memory untouched
// - Low nibbles swapped with byte at R0/R1
// - Long target high byte first; call pushes low first
// - Direct operand is byte after opcode
// - Immediate follows opcode, after any direct byte
// - Relative offset added to fully advanced counter
// - Opcode c5 swaps accumulator with direct byte
// - Page target: opcode top bits plus byte two
// - Page target within advanced counter's 2K page
package instr_pkg;

  // Reset values
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [7:0]  SP_RST   = 8'h07;
  localparam logic [7:0]  BYTE_RST = 8'h00;

  // Whole opcodes
  localparam logic [7:0] OP_LONG_JUMP   = 8'h02;
  localparam logic [7:0] OP_LONG_CALL   = 8'h12;
  localparam logic [7:0] OP_RETURN      = 8'h22;
  localparam logic [7:0] OP_RETURN_INT  = 8'h32;
  localparam logic [7:0] OP_JUMP_C      = 8'h40;
  localparam logic [7:0] OP_JUMP_NC     = 8'h50;
  localparam logic [7:0] OP_JUMP_Z      = 8'h60;
  localparam logic [7:0] OP_JUMP_NZ     = 8'h70;
  localparam logic [7:0] OP_SHORT_JUMP  = 8'h80;
  localparam logic [7:0] OP_JUMP_IND    = 8'h73;
  localparam logic [7:0] OP_MOV_DIR_IMM = 8'h75;
  localparam logic [7:0] OP_LOAD_PTR    = 8'h90;
  localparam logic [7:0] OP_INC_PTR     = 8'ha3;
  localparam logic [7:0] OP_CPL_C       = 8'hb3;
  localparam logic [7:0] OP_PUSH        = 8'hc0;
  localparam logic [7:0] OP_CLR_C       = 8'hc3;
  localparam logic [7:0] OP_POP         = 8'hd0;
  localparam logic [7:0] OP_SET_C       = 8'hd3;
  localparam logic [7:0] OP_MOV_A_DIR   = 8'he5;
  localparam logic [7:0] OP_MOV_DIR_A   = 8'hf5;

  // Opcode high nibble groups
  localparam logic [3:0] HI_PLUS  = 4'h0;
  localparam logic [3:0] HI_MINUS = 4'h1;
  localparam logic [3:0] HI_OR    = 4'h4;
  localparam logic [3:0] HI_AND   = 4'h5;
  localparam logic [3:0] HI_XOR   = 4'h6;
  localparam logic [3:0] HI_MOV   = 4'h7;
  localparam logic [3:0] HI_CMP   = 4'hb;
  localparam logic [3:0] HI_SWAP  = 4'hc;
  localparam logic [3:0] HI_NIB   = 4'hd;

  // Opcode low nibble forms
  localparam logic [3:0] LO_REL     = 4'h0;
  localparam logic [3:0] LO_PAGE    = 4'h1;
  localparam logic [3:0] LO_DIR_A   = 4'h2;
  localparam logic [3:0] LO_DIR_IMM = 4'h3;
  localparam logic [3:0] LO_A_IMM   = 4'h4;
  localparam logic [3:0] LO_DIR     = 4'h5;
  localparam logic [2:0] LO_IND     = 3'h3;

  typedef enum logic [2:0] {fn_and, fn_or, fn_xor, fn_plus, fn_minus, fn_swap, fn_nib} alu_fn_e;

  typedef enum logic [3:0] {
    st_fetch, st_decode, st_ptr, st_ptr_wait, st_read, st_exec,
    st_push_lo, st_push_hi, st_pop_hi, st_pop_lo, st_pop_done
  } state_e;

  // Bytes per instruction; unknown opcodes count as one byte, or two when the low nibble is 5
  function automatic logic [1:0] instr_len(input logic [7:0] op);
    logic [3:0] hi;
    logic [3:0] lo;
    logic       grp;
    hi  = op[7:4];
    lo  = op[3:0];
    grp = (hi == HI_OR) || (hi == HI_AND) || (hi == HI_XOR);
    if (op == OP_LONG_JUMP || op == OP_LONG_CALL || op == OP_LOAD_PTR || op == OP_MOV_DIR_IMM ||
        (hi == HI_CMP && lo >= LO_A_IMM) || (grp && lo == LO_DIR_IMM)) begin
      instr_len = 2'h3;
    end else if (lo == LO_PAGE || lo == LO_DIR || (grp && lo == LO_DIR_A) ||
                 ((grp || hi == HI_MOV) && lo == LO_A_IMM) || (hi == HI_MOV && op[3]) ||
                 (lo == LO_REL && (op == OP_JUMP_C || op == OP_JUMP_NC || op == OP_JUMP_Z ||
                  op == OP_JUMP_NZ || op == OP_SHORT_JUMP || op == OP_PUSH || op == OP_POP))) begin
      instr_len = 2'h2;
    end else begin
      instr_len = 2'h1;
    end
  endfunction : instr_len

endpackage : instr_pkg

// >>> core/iram_if.sv
interface iram_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic [7:0] rdata;

  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface : iram_if

// >>> core/iram.sv
module iram
  import instr_pkg::*;
#(
  parameter int unsigned DEPTH = 256
)
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Access port
  iram_if.mem       port
);
  logic [7:0] mem_q [DEPTH];
  logic [7:0] rdata_ff;

  // Read during write returns the old byte
  always_ff @(posedge i_clk) begin
    if (port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= BYTE_RST;
    end else begin
      rdata_ff <= mem_q[port.addr];
    end
  end

  assign port.rdata = rdata_ff;
endmodule : iram

// >>> core/byte_logic_unit.sv
module byte_logic_unit
  import instr_pkg::*;
(
  // Function select
  input  wire alu_fn_e    i_fn,
  // Operands
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  // Results
  output logic [7:0]      o_y,
  output logic [7:0]      o_swap
);
  always_comb begin
    o_swap = i_a;
    case (i_fn)
      fn_and:   o_y = i_a & i_b;
      fn_or:    o_y = i_a | i_b;
      fn_xor:   o_y = i_a ^ i_b;
      fn_plus:  o_y = i_a + 8'h01;
      fn_minus: o_y = i_a - 8'h01;
      fn_nib: begin
        o_y    = {i_a[7:4], i_b[3:0]};
        o_swap = {i_b[7:4], i_a[3:0]};
      end
      default:  o_y = i_b;
    endcase
  end
endmodule : byte_logic_unit

// >>> core/cpu_instruction_set_decode.sv
module cpu_instruction_set_decode
  import instr_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Program memory fetch
  output logic [15:0]      o_code_addr,
  output logic             o_code_rd,
  input  wire logic [7:0]  i_code_data,
  input  wire logic        i_code_valid,
  // Datapath state
  output logic [7:0]       o_acc,
  output logic [7:0]       o_sp,
  output logic [15:0]      o_data_pointer,
  output logic             o_carry,
  output logic             o_retire
);
  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  state_e      state_ff;
  state_e      nxt_state;
  logic [1:0]  cnt_ff;
  logic [1:0]  nxt_cnt;
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  logic [15:0] tgt_ff;
  logic [15:0] nxt_tgt;
  logic [15:0] dp_ff;
  logic [15:0] nxt_dp;
  logic [7:0]  op_ff;
  logic [7:0]  nxt_op;
  logic [7:0]  b1_ff;
  logic [7:0]  nxt_b1;
  logic [7:0]  b2_ff;
  logic [7:0]  nxt_b2;
  logic [7:0]  acc_ff;
  logic [7:0]  nxt_acc;
  logic [7:0]  sp_ff;
  logic [7:0]  nxt_sp;
  logic [7:0]  ea_ff;
  logic [7:0]  nxt_ea;
  logic        carry_ff;
  logic        nxt_carry;
  logic        retire_ff;
  logic        nxt_retire;
  logic [7:0]  alu_y;
  logic [7:0]  alu_swap;

  iram_if ram ();

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Opcode fields
  wire logic [3:0]  hi        = op_ff[7:4];
  wire logic [3:0]  lo        = op_ff[3:0];
  wire logic [7:0]  m         = ram.rdata;
  wire logic [7:0]  cur_op    = (cnt_ff == 2'h0) ? i_code_data : op_ff;
  wire logic        last_byte = (cnt_ff + 2'h1) == instr_len(cur_op);
  wire logic        grp_logic = (hi == HI_OR) || (hi == HI_AND) || (hi == HI_XOR);
  wire logic        grp_step  = (hi == HI_PLUS) || (hi == HI_MINUS);
  wire logic        use_bank  = op_ff[3];
  wire logic        use_ind   = op_ff[3:1] == LO_IND;
  wire logic [7:0]  ptr_addr  = {7'h00, op_ff[0]};
  wire logic [7:0]  bank_addr = {5'h00, op_ff[2:0]};
  wire logic        is_swap   = (hi == HI_SWAP) && (lo >= LO_DIR);
  wire logic        is_nib    = (hi == HI_NIB) && use_ind;
  wire logic        is_cmp    = (hi == HI_CMP) && (lo >= LO_A_IMM);

  // Operand bytes
  wire logic [7:0]  imm       = (lo == LO_DIR_IMM) ? b2_ff : b1_ff;
  wire logic [7:0]  rel       = (instr_len(op_ff) == 2'h3) ? b2_ff : b1_ff;
  wire logic [15:0] rel_tgt   = pc_ff + {{8{rel[7]}}, rel};
  wire logic [15:0] page_tgt  = {pc_ff[15:11], op_ff[7:5], b1_ff};
  wire logic [15:0] long_tgt  = {b1_ff, b2_ff};

  // Memory operand needed before execution
  wire logic need_read = (grp_logic && lo >= LO_DIR_A && lo != LO_A_IMM) ||
                         (grp_step && lo >= LO_DIR) || is_swap || is_nib ||
                         (is_cmp && lo != LO_A_IMM) ||
                         op_ff == OP_PUSH || op_ff == OP_POP || op_ff == OP_MOV_A_DIR;

  // Logic unit steering
  wire logic    to_mem  = (grp_logic && (lo == LO_DIR_A || lo == LO_DIR_IMM)) ||
                          (grp_step && lo != LO_A_IMM);
  wire alu_fn_e fn      = (hi == HI_PLUS)  ? fn_plus  :
                          (hi == HI_MINUS) ? fn_minus :
                          (hi == HI_AND)   ? fn_and   :
                          (hi == HI_OR)    ? fn_or    :
                          (hi == HI_XOR)   ? fn_xor   :
                          is_nib           ? fn_nib   : fn_swap;
  wire logic [7:0] alu_a = (grp_step && lo != LO_A_IMM) ? m :
                           (grp_logic && (lo == LO_DIR_IMM || lo == LO_A_IMM)) ? imm : acc_ff;
  wire logic [7:0] alu_b = (grp_logic && lo == LO_A_IMM) ? acc_ff : m;

  // Compare and branch operands
  wire logic [7:0] cmp_x = (lo <= LO_DIR) ? acc_ff : m;
  wire logic [7:0] cmp_y = (lo == LO_DIR) ? m : b1_ff;

  // Short jump and conditional relative branches
  wire logic rel_take = (op_ff == OP_SHORT_JUMP) ||
                        (op_ff == OP_JUMP_C && carry_ff) ||
                        (op_ff == OP_JUMP_NC && !carry_ff) ||
                        (op_ff == OP_JUMP_Z && acc_ff == BYTE_RST) ||
                        (op_ff == OP_JUMP_NZ && acc_ff != BYTE_RST);

  byte_logic_unit u_alu (
    .i_fn   (fn),
    .i_a    (alu_a),
    .i_b    (alu_b),
    .o_y    (alu_y),
    .o_swap (alu_swap)
  );

  iram u_iram (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .port    (ram.mem)
  );

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_pc     = pc_ff;
    nxt_tgt    = tgt_ff;
    nxt_dp     = dp_ff;
    nxt_op     = op_ff;
    nxt_b1     = b1_ff;
    nxt_b2     = b2_ff;
    nxt_acc    = acc_ff;
    nxt_sp     = sp_ff;
    nxt_ea     = ea_ff;
    nxt_carry  = carry_ff;
    nxt_retire = 1'b0;
    ram.addr   = ea_ff;
    ram.wdata  = alu_y;
    ram.we     = 1'b0;
    case (state_ff)
      st_fetch: begin
        if (i_code_valid) begin
          nxt_pc = pc_ff + 16'h0001;
          if (cnt_ff == 2'h0) begin
            nxt_op = i_code_data;
          end else if (cnt_ff == 2'h1) begin
            nxt_b1 = i_code_data;
          end else begin
            nxt_b2 = i_code_data;
          end
          if (last_byte) begin
            nxt_cnt   = 2'h0;
            nxt_state = st_decode;
          end else begin
            nxt_cnt = cnt_ff + 2'h1;
          end
        end
      end
      st_decode: begin
        nxt_ea = (op_ff == OP_POP) ? sp_ff : use_bank ? bank_addr : b1_ff;
        if (need_read && use_ind) begin
          nxt_state = st_ptr;
        end else if (need_read) begin
          nxt_state = st_read;
        end else begin
          nxt_state = st_exec;
        end
      end
      st_ptr: begin
        ram.addr  = ptr_addr;
        nxt_state = st_ptr_wait;
      end
      st_ptr_wait: begin
        nxt_ea    = m;
        nxt_state = st_read;
      end
      st_read: begin
        nxt_state = st_exec;
      end
      st_exec: begin
        nxt_state  = st_fetch;
        nxt_retire = 1'b1;
        if ((grp_logic && lo >= LO_DIR_A) || (grp_step && lo >= LO_A_IMM)) begin
          if (to_mem) begin
            ram.we = 1'b1;
          end else begin
            nxt_acc = alu_y;
          end
        end else if (is_swap || is_nib) begin
          nxt_acc   = alu_y;
          ram.we    = 1'b1;
          ram.wdata = alu_swap;
        end else if (is_cmp) begin
          if (cmp_x != cmp_y) begin
            nxt_pc = rel_tgt;
          end
          nxt_carry = cmp_x < cmp_y;
        end else begin
          case (op_ff)
            OP_MOV_A_DIR: nxt_acc = m;
            OP_MOV_DIR_A: begin
              ram.we    = 1'b1;
              ram.wdata = acc_ff;
            end
            OP_MOV_DIR_IMM: begin
              ram.we    = 1'b1;
              ram.wdata = b2_ff;
            end
            OP_PUSH: begin
              ram.addr  = sp_ff + 8'h01;
              ram.we    = 1'b1;
              ram.wdata = m;
              nxt_sp    = sp_ff + 8'h01;
            end
            OP_POP: begin
              ram.addr  = b1_ff;
              ram.we    = 1'b1;
              ram.wdata = m;
              nxt_sp    = sp_ff - 8'h01;
            end
            OP_LONG_JUMP: nxt_pc = long_tgt;
            OP_LONG_CALL: begin
              nxt_tgt    = long_tgt;
              nxt_state  = st_push_lo;
              nxt_retire = 1'b0;
            end
            OP_RETURN, OP_RETURN_INT: begin
              nxt_state  = st_pop_hi;
              nxt_retire = 1'b0;
            end
            OP_LOAD_PTR: nxt_dp = {b1_ff, b2_ff};
            OP_INC_PTR:  nxt_dp = dp_ff + 16'h0001;
            OP_JUMP_IND: nxt_pc = {8'h00, acc_ff} + dp_ff;
            OP_CLR_C:    nxt_carry = 1'b0;
            OP_SET_C:    nxt_carry = 1'b1;
            OP_CPL_C:    nxt_carry = !carry_ff;
            default: begin
              if (lo == LO_PAGE && op_ff[4]) begin
                nxt_tgt    = page_tgt;
                nxt_state  = st_push_lo;
                nxt_retire = 1'b0;
              end else if (lo == LO_PAGE) begin
                nxt_pc = page_tgt;
              end else if (lo == LO_REL && rel_take) begin
                nxt_pc = rel_tgt;
              end else if (hi == HI_MOV && lo == LO_A_IMM) begin
                nxt_acc = b1_ff;
              end else if (hi == HI_MOV && use_bank) begin
                ram.we    = 1'b1;
                ram.wdata = b1_ff;
              end
            end
          endcase
        end
      end
      // Return address goes low byte first, then high
      st_push_lo: begin
        ram.addr  = sp_ff + 8'h01;
        ram.we    = 1'b1;
        ram.wdata = pc_ff[7:0];
        nxt_sp    = sp_ff + 8'h01;
        nxt_state = st_push_hi;
      end
      st_push_hi: begin
        ram.addr   = sp_ff + 8'h01;
        ram.we     = 1'b1;
        ram.wdata  = pc_ff[15:8];
        nxt_sp     = sp_ff + 8'h01;
        nxt_pc     = tgt_ff;
        nxt_retire = 1'b1;
        nxt_state  = st_fetch;
      end
      st_pop_hi: begin
        ram.addr  = sp_ff;
        nxt_sp    = sp_ff - 8'h01;
        nxt_state = st_pop_lo;
      end
      st_pop_lo: begin
        ram.addr      = sp_ff;
        nxt_tgt[15:8] = m;
        nxt_sp        = sp_ff - 8'h01;
        nxt_state     = st_pop_done;
      end
      st_pop_done: begin
        nxt_pc     = {tgt_ff[15:8], m};
        nxt_retire = 1'b1;
        nxt_state  = st_fetch;
      end
      default: nxt_state = st_fetch;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= st_fetch;
      cnt_ff    <= 2'h0;
      pc_ff     <= PC_RST;
      tgt_ff    <= PC_RST;
      dp_ff     <= PC_RST;
      retire_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      pc_ff     <= nxt_pc;
      tgt_ff    <= nxt_tgt;
      dp_ff     <= nxt_dp;
      retire_ff <= nxt_retire;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_ff    <= BYTE_RST;
      b1_ff    <= BYTE_RST;
      b2_ff    <= BYTE_RST;
      acc_ff   <= BYTE_RST;
      sp_ff    <= SP_RST;
      ea_ff    <= BYTE_RST;
      carry_ff <= 1'b0;
    end else begin
      op_ff    <= nxt_op;
      b1_ff    <= nxt_b1;
      b2_ff    <= nxt_b2;
      acc_ff   <= nxt_acc;
      sp_ff    <= nxt_sp;
      ea_ff    <= nxt_ea;
      carry_ff <= nxt_carry;
    end
  end

  // Fetch request is combinational so a ready memory costs no cycle
  assign o_code_rd      = state_ff == st_fetch;
  assign o_code_addr    = pc_ff;
  assign o_acc          = acc_ff;
  assign o_sp           = sp_ff;
  assign o_data_pointer = dp_ff;
  assign o_carry        = carry_ff;
  assign o_retire       = retire_ff;
endmodule : cpu_instruction_set_decode

// >>> dv/code_rom_model.sv
module code_rom_model (
  // Clock and control from the bench
  input  wire logic        i_clk,
  input  wire logic        i_en,
  input  wire logic        i_slow,
  // Fetch request from the core
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd,
  // Answer to the core
  output logic [7:0]       o_data,
  output logic             o_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] rom [0:65535];
  logic       phase_ff = 1'b0;
  logic [7:0] last_ff  = 8'h00;

  // Slow mode answers every other cycle only
  assign o_valid = i_en && i_rd && (!i_slow || phase_ff);
  // Idle bus shows the inverse, so a stale byte is never mistaken for a fresh one
  assign o_data  = o_valid ? rom[i_addr] : ~last_ff;

  always_ff @(posedge i_clk) begin
    phase_ff <= ~phase_ff;
    if (o_valid) begin
      last_ff <= o_data;
    end
  end
endmodule : code_rom_model

// >>> dv/cpu_instruction_set_decode_chk.sv
module cpu_instruction_set_decode_chk (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Fetch port
  input  wire logic [15:0] o_code_addr,
  input  wire logic        o_code_rd,
  input  wire logic [7:0]  i_code_data,
  input  wire logic        i_code_valid,
  // Datapath state
  input  wire logic [7:0]  o_acc,
  input  wire logic [7:0]  o_sp,
  input  wire logic [15:0] o_data_pointer,
  input  wire logic        o_carry,
  input  wire logic        o_retire
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0]  op_ff, b2_ff, b3_ff, acc0_ff, sp0_ff;
  logic [15:0] pc0_ff;
  logic [1:0]  cnt_ff;

  wire         take  = o_code_rd && i_code_valid;
  wire         first = take && (o_retire || cnt_ff == 2'h0);
  wire  [15:0] rel2  = pc0_ff + 16'h0002 + {{8{b2_ff[7]}}, b2_ff};
  wire  [15:0] rel3  = pc0_ff + 16'h0003 + {{8{b3_ff[7]}}, b3_ff};
  wire  [15:0] adv2  = pc0_ff + 16'h0002;
  wire  [15:0] page  = {adv2[15:11], op_ff[7:5], b2_ff};

  // Opcode bytes and entry state of the instruction in flight
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {op_ff, b2_ff, b3_ff, acc0_ff, sp0_ff, pc0_ff, cnt_ff} <= '0;
    end else if (first) begin
      {op_ff, pc0_ff, acc0_ff, sp0_ff, cnt_ff} <= {i_code_data, o_code_addr, o_acc, o_sp, 2'h1};
    end else if (take && cnt_ff == 2'h1) begin
      {b2_ff, cnt_ff} <= {i_code_data, 2'h2};
    end else if (take) begin
      b3_ff <= i_code_data;
    end else if (o_retire) begin
      cnt_ff <= 2'h0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  long_jump_a: assert property (o_retire && op_ff == 8'h02 |-> o_code_addr == {b2_ff, b3_ff})
    else $error("long jump target wrong");
  long_call_a: assert property (o_retire && op_ff == 8'h12 |-> o_code_addr == {b2_ff, b3_ff} && o_sp == sp0_ff + 8'h02)
    else $error("long call target or stack wrong");
  page_target_a: assert property (o_retire && op_ff[3:0] == 4'h1 |-> o_code_addr == page)
    else $error("page target wrong");
  short_jump_a: assert property (o_retire && op_ff == 8'h80 |-> o_code_addr == rel2)
    else $error("relative target wrong");
  cmp_branch_a: assert property (o_retire && op_ff == 8'hb4 |-> o_carry == (acc0_ff < b2_ff) &&
                                 o_code_addr == ((acc0_ff != b2_ff) ? rel3 : pc0_ff + 16'h0003))
    else $error("compare branch wrong");
  and_acc_keep_a: assert property (o_retire && op_ff == 8'h52 |-> o_acc == acc0_ff)
    else $error("accumulator changed by and into memory");
  or_imm_a: assert property (o_retire && op_ff == 8'h44 |-> o_acc == (acc0_ff | b2_ff))
    else $error("or immediate result wrong");
  nib_keep_a: assert property (o_retire && op_ff[7:1] == 7'h6b |-> o_acc[7:4] == acc0_ff[7:4])
    else $error("upper nibble not kept");
  dir_swap_len_a: assert property (o_retire && op_ff == 8'hc5 |-> o_code_addr == pc0_ff + 16'h0002)
    else $error("direct exchange length wrong");
  and_imm_len_a: assert property (o_retire && op_ff == 8'h53 |-> o_code_addr == pc0_ff + 16'h0003 && o_acc == acc0_ff)
    else $error("and immediate into memory wrong");
  retire_pulse_a: assert property (o_retire |=> !o_retire && $stable(o_acc))
    else $error("retire not a single pulse");
endmodule : cpu_instruction_set_decode_chk

// >>> dv/test_cpu_instruction_set_decode.sv
module test_cpu_instruction_set_decode;
  import instr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk;
  logic        i_arst_n;
  logic        mem_en;
  logic        mem_slow;
  logic [15:0] o_code_addr;
  logic        o_code_rd;
  logic [7:0]  i_code_data;
  logic        i_code_valid;
  logic [7:0]  o_acc;
  logic [7:0]  o_sp;
  logic [15:0] o_data_pointer;
  logic        o_carry;
  logic        o_retire;
  int          err_count;
  int          n_compared;
  logic [15:0] wp;
  logic [15:0] org;

  cpu_instruction_set_decode i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .o_code_addr(o_code_addr),
    .o_code_rd(o_code_rd), .i_code_data(i_code_data), .i_code_valid(i_code_valid), .o_acc(o_acc),
    .o_sp(o_sp), .o_data_pointer(o_data_pointer), .o_carry(o_carry), .o_retire(o_retire));
  code_rom_model i_mem (.i_clk(i_clk), .i_en(mem_en), .i_slow(mem_slow), .i_addr(o_code_addr),
    .i_rd(o_code_rd), .o_data(i_code_data), .o_valid(i_code_valid));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic put(input int n, input logic [7:0] b0, input logic [7:0] b1 = 8'h00,
                     input logic [7:0] b2 = 8'h00);
    logic [7:0] b [3];
    b = '{b0, b1, b2};
    for (int i = 0; i < n; i++) begin
      i_mem.rom[wp] = b[i];
      wp = wp + 16'h0001;
    end
  endtask : put

  // Bounded wait for each completion pulse
  task automatic step(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge i_clk);
        #1;
        k++;
      end while (o_retire !== 1'b1 && k < 200);
      if (o_retire !== 1'b1) begin
        err_count++;
        $display("CHECK FAILED retire expected 1 seen %b", o_retire);
        give_verdict();
      end
    end
  endtask : step

  task automatic t_reset();
    check("acc", {8'h00, o_acc}, 16'h0000);
    check("sp", {8'h00, o_sp}, {8'h00, SP_RST});
    check("data pointer", o_data_pointer, 16'h0000);
    check("carry", {15'h0000, o_carry}, 16'h0000);
    check("addr", o_code_addr, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_and();
    put(3, 8'h75, 8'h30, 8'h5c);
    put(3, 8'h53, 8'h30, 8'h0f);
    put(2, 8'he5, 8'h30);
    step(3);
    check("acc", {8'h00, o_acc}, 16'h000c);
    check("addr", o_code_addr, 16'h0008);
    put(2, 8'h74, 8'ha5);
    put(2, 8'h52, 8'h30);
    step(2);
    check("acc", {8'h00, o_acc}, 16'h00a5);
    put(2, 8'he5, 8'h30);
    step(1);
    check("mem", {8'h00, o_acc}, 16'h0004);
    $display("test and done");
  endtask : t_and

  task automatic t_decrement_or();
    put(3, 8'h75, 8'h31, 8'h00);
    put(2, 8'h15, 8'h31);
    put(2, 8'he5, 8'h31);
    step(3);
    check("decrement wrap", {8'h00, o_acc}, 16'h00ff);
    put(3, 8'h75, 8'h32, 8'h0f);
    put(2, 8'h74, 8'h30);
    put(2, 8'h44, 8'h01);
    put(2, 8'h45, 8'h32);
    step(4);
    check("or", {8'h00, o_acc}, 16'h003f);
    put(2, 8'he5, 8'h32);
    step(1);
    check("mem", {8'h00, o_acc}, 16'h000f);
    put(2, 8'hc0, 8'h31);
    put(2, 8'hd0, 8'h32);
    put(2, 8'he5, 8'h32);
    put(3, 8'h90, 8'h12, 8'h34);
    put(1, 8'ha3);
    step(5);
    check("pop", {8'h00, o_acc}, 16'h00ff);
    check("sp", {8'h00, o_sp}, {8'h00, SP_RST});
    check("data pointer", o_data_pointer, 16'h1235);
    $display("test decrement or done");
  endtask : t_decrement_or

  task automatic t_xch();
    put(3, 8'h75, 8'h01, 8'h40);
    put(3, 8'h75, 8'h40, 8'h5a);
    put(2, 8'h74, 8'hc3);
    put(1, 8'hc7);
    step(4);
    check("swap ind", {8'h00, o_acc}, 16'h005a);
    put(1, 8'hd7);
    step(1);
    check("nibble", {8'h00, o_acc}, 16'h0053);
    put(2, 8'he5, 8'h40);
    step(1);
    check("mem", {8'h00, o_acc}, 16'h00ca);
    put(3, 8'h75, 8'h33, 8'h77);
    put(2, 8'h74, 8'h11);
    org = wp;
    put(2, 8'hc5, 8'h33);
    step(3);
    check("swap dir", {8'h00, o_acc}, 16'h0077);
    check("addr", o_code_addr, org + 16'h0002);
    put(2, 8'he5, 8'h33);
    step(1);
    check("mem", {8'h00, o_acc}, 16'h0011);
    $display("test exchange done");
  endtask : t_xch

  // Slow fetch here to stretch multi-byte instructions
  task automatic t_long();
    logic [15:0] ret;
    org = wp;
    ret = org + 16'h0003;
    put(3, 8'h12, 8'h12, 8'h34);
    wp = 16'h1234;
    put(2, 8'he5, 8'h08);
    put(2, 8'he5, 8'h09);
    put(1, 8'h22);
    // Code must be in place before the next edge, the core fetches at once
    @(posedge i_clk);
    mem_slow <= 1'b1;
    #1;
    step(1);
    check("call addr", o_code_addr, 16'h1234);
    check("call sp", {8'h00, o_sp}, {8'h00, SP_RST + 8'h02});
    step(1);
    check("push lo", {8'h00, o_acc}, {8'h00, ret[7:0]});
    step(1);
    check("push hi", {8'h00, o_acc}, {8'h00, ret[15:8]});
    step(1);
    check("ret addr", o_code_addr, ret);
    wp = ret;
    put(3, 8'h02, 8'h07, 8'hfe);
    wp = 16'h07fe;
    put(2, 8'h21, 8'h23);
    step(1);
    check("jump addr", o_code_addr, 16'h07fe);
    step(1);
    check("page next", o_code_addr, 16'h0923);
    wp = 16'h0923;
    $display("test long done");
  endtask : t_long

  task automatic t_rel();
    org = wp;
    put(2, 8'h80, 8'h05);
    wp = org + 16'h0007;
    put(2, 8'h80, 8'hf0);
    @(posedge i_clk);
    mem_slow <= 1'b0;
    #1;
    step(1);
    check("fwd", o_code_addr, org + 16'h0007);
    step(1);
    check("back", o_code_addr, org - 16'h0007);
    wp = org - 16'h0007;
    put(2, 8'h74, 8'h10);
    put(3, 8'hb4, 8'h20, 8'h04);
    step(2);
    check("cmp carry", {15'h0000, o_carry}, 16'h0001);
    check("cmp taken", o_code_addr, org + 16'h0002);
    wp = org + 16'h0002;
    put(3, 8'hb4, 8'h10, 8'h04);
    put(2, 8'h40, 8'h10);
    step(1);
    check("cmp equal", {15'h0000, o_carry}, 16'h0000);
    check("cmp fall", o_code_addr, org + 16'h0005);
    step(1);
    check("jc fall", o_code_addr, org + 16'h0007);
    $display("test relative done");
  endtask : t_rel

  initial begin
    i_arst_n   = 1'b0;
    mem_en     = 1'b0;
    mem_slow   = 1'b0;
    err_count  = 0;
    n_compared = 0;
    wp         = 16'h0000;
    repeat (16) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    t_reset();
    @(posedge i_clk);
    mem_en <= 1'b1;
    #1;
    t_and();
    t_decrement_or();
    t_xch();
    t_long();
    t_rel();
    give_verdict();
  end
endmodule : test_cpu_instruction_set_decode

bind cpu_instruction_set_decode cpu_instruction_set_decode_chk i_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .o_code_addr(o_code_addr), .o_code_rd(o_code_rd), .i_code_data(i_code_data), .i_code_valid(i_code_valid),
  .o_acc(o_acc), .o_sp(o_sp), .o_data_pointer(o_data_pointer), .o_carry(o_carry), .o_retire(o_retire));
